// *** src/pmc_config_regs.sv ***
`timescale 1ns/1ps
`default_nettype none


module pmc_config_regs
  import pmc_pkg::*;
#(
  parameter bit STRAP_ENABLE = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PMC_ADDR_W-1:0] paddr,
  input wire logic [PMC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [PMC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic strap_parallel_if_en,
  input wire logic serial_page_in,
  input wire logic serial_done_in,
  output logic parallel_if_enable,
  output logic [1:0] rx_fifo_midlevel,
  output logic [1:0] tx_fifo_midlevel,
  output logic tx_clk_shifted,
  output logic rx_clk_shifted,
  output logic async_fifo_skip,
  output logic async_skip_clock_lag,
  output logic low_latency_10_100,
  output logic unlock_timeout_off,
  output logic [3:0] unlock_recovery_ms,
  output logic force_link_good,
  output logic enhanced_line_code_detect,
  output logic enhanced_gap_detect,
  output logic scrambling_off,
  output logic odd_nibble_detect,
  output logic early_receive_valid
);

  localparam logic [15:0] CTRL_RESET =
    STRAP_ENABLE ? PMC_CTRL_RST_STRAP : PMC_CTRL_RST;
  // the agreement flop settles one edge after the settle count; load then
  localparam logic [2:0] STRAP_LOAD = {1'b0, PMC_STRAP_SETTLE} + 3'h1;

  logic [15:0] ctrl;
  logic [15:0] ctrl2;
  logic [15:0] fe_cfg;
  logic page_sync;
  logic done_sync;
  logic strap_sync;
  logic [2:0] strap_cnt;
  logic strap_taken;
  logic wr_done;
  logic access;
  logic [15:0] next_wdata;

  // address decode shared by reads and writes
  function automatic logic hit(input logic [PMC_ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == {2'h0, idx, 2'h0});
  endfunction

  function automatic logic mapped(input logic [PMC_ADDR_W-1:0] a);
    mapped = hit(a, PMC_IDX_CTRL) || hit(a, PMC_IDX_CTRL2) ||
             hit(a, PMC_IDX_NEG_STS) || hit(a, PMC_IDX_FE_CFG);
  endfunction

  // status inputs come from the serial PCS domain
  pmc_sync3 u_sync_page (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(serial_page_in),
    .dout(page_sync)
  );

  pmc_sync3 u_sync_done (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(serial_done_in),
    .dout(done_sync)
  );

  pmc_sync3 u_sync_strap (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(strap_parallel_if_en),
    .dout(strap_sync)
  );

  // read word assembly; reserved bits read zero
  function automatic logic [15:0] rd_word(input logic [PMC_ADDR_W-1:0] a,
                                          input logic [15:0] c1,
                                          input logic [15:0] c2,
                                          input logic pg,
                                          input logic dn,
                                          input logic [15:0] fe);
    logic [15:0] w;
    w = 16'h0000;
    if (hit(a, PMC_IDX_CTRL)) begin
      w = c1 & PMC_CTRL_MASK;
    end else if (hit(a, PMC_IDX_CTRL2)) begin
      w = c2 & PMC_CTRL2_MASK;
    end else if (hit(a, PMC_IDX_NEG_STS)) begin
      w[PMC_STS_PAGE_BIT] = pg;
      w[PMC_STS_DONE_BIT] = dn;
    end else if (hit(a, PMC_IDX_FE_CFG)) begin
      w = fe & PMC_FE_MASK;
    end
    rd_word = w;
  endfunction

  assign access = ce && psel && penable && !pready;
  assign wr_done = ce && psel && penable && pready && pwrite;

  // byte strobes gate the two low lanes that hold the 16-bit registers
  always_comb begin
    next_wdata = {pstrb[1] ? pwdata[15:8] : 8'h00,
                  pstrb[0] ? pwdata[7:0] : 8'h00};
  end

  // one wait state: pready rises on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (ce) begin
      pready <= access;
      pslverr <= access && !mapped(paddr);
      if (access && !pwrite) begin
        prdata <= {16'h0000,
                   rd_word(paddr, ctrl, ctrl2, page_sync, done_sync,
                           fe_cfg)};
      end
    end
  end

  // strap is caught once the synchroniser has settled after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt <= 3'h0;
      strap_taken <= 1'b0;
    end else if (ce && !strap_taken) begin
      if (strap_cnt == STRAP_LOAD) begin
        strap_taken <= 1'b1;
      end else begin
        strap_cnt <= strap_cnt + 3'h1;
      end
    end
  end

  // interface control; a lane not strobed keeps its old bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (ce) begin
      if (wr_done && hit(paddr, PMC_IDX_CTRL) && pstrb[0]) begin
        ctrl[7:0] <= next_wdata[7:0] & PMC_CTRL_MASK[7:0];
        ctrl[15:8] <= 8'h00;
      end else if (STRAP_ENABLE && !strap_taken &&
                   strap_cnt == STRAP_LOAD) begin
        ctrl[PMC_CTRL_EN_BIT] <= strap_sync;
      end
    end
  end

  // second interface control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl2 <= PMC_CTRL2_RST;
    end else if (ce && wr_done && hit(paddr, PMC_IDX_CTRL2)) begin
      ctrl2[7:0] <= pstrb[0] ? (next_wdata[7:0] & PMC_CTRL2_MASK[7:0])
                             : ctrl2[7:0];
      ctrl2[15:8] <= 8'h00;
    end
  end

  // fast ethernet receive configuration; both lanes carry fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fe_cfg <= PMC_FE_RST;
    end else if (ce && wr_done && hit(paddr, PMC_IDX_FE_CFG)) begin
      if (pstrb[0]) begin
        fe_cfg[7:0] <= next_wdata[7:0] & PMC_FE_MASK[7:0];
      end
      if (pstrb[1]) begin
        fe_cfg[15:8] <= next_wdata[15:8] & PMC_FE_MASK[15:8];
      end
    end
  end

  // control outputs come straight from register bits
  assign parallel_if_enable = ctrl[PMC_CTRL_EN_BIT];
  // codes pass unchanged; the FIFO reads larger as deeper
  assign rx_fifo_midlevel = ctrl[PMC_CTRL_RXTHR_LO +: 2];
  assign tx_fifo_midlevel = ctrl[PMC_CTRL_TXTHR_LO +: 2];
  assign tx_clk_shifted = ctrl[PMC_CTRL_TXSHIFT_BIT];
  assign rx_clk_shifted = ctrl[PMC_CTRL_RXSHIFT_BIT];
  assign async_fifo_skip = ctrl2[PMC_CTRL2_SKIP_BIT];
  assign async_skip_clock_lag = ctrl2[PMC_CTRL2_LAG_BIT];
  assign low_latency_10_100 = ctrl2[PMC_CTRL2_LOWLAT_BIT];
  assign unlock_timeout_off = fe_cfg[PMC_FE_TOOFF_BIT];
  assign unlock_recovery_ms = fe_cfg[PMC_FE_RECOV_LO +: 4];
  assign force_link_good = fe_cfg[PMC_FE_FORCE_BIT];
  assign enhanced_line_code_detect = fe_cfg[PMC_FE_LINECODE_BIT];
  assign enhanced_gap_detect = fe_cfg[PMC_FE_GAP_BIT];
  assign scrambling_off = fe_cfg[PMC_FE_SCROFF_BIT];
  assign odd_nibble_detect = fe_cfg[PMC_FE_ODD_BIT];
  assign early_receive_valid = fe_cfg[PMC_FE_EARLY_BIT];

  // checks on the slave and register behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr_ctrl;
    wr_done && hit(paddr, PMC_IDX_CTRL) && pstrb[0];
  endsequence

  sequence s_wr_fe_lo;
    wr_done && hit(paddr, PMC_IDX_FE_CFG) && pstrb[0];
  endsequence

  sequence s_wr_ctrl2;
    wr_done && hit(paddr, PMC_IDX_CTRL2) && pstrb[0];
  endsequence

  sequence s_rd_start(logic [7:0] idx);
    access && !pwrite && hit(paddr, idx);
  endsequence

  AST_UPPER_ZERO: assert property (
    s_rd_start(PMC_IDX_CTRL) |=> prdata[15:PMC_CTRL_UPPER_LO] == 8'h00)
    else $error("control upper byte not zero");

  AST_ENABLE_WRITE: assert property (
    s_wr_ctrl |=> parallel_if_enable == $past(pwdata[PMC_CTRL_EN_BIT]))
    else $error("interface enable did not follow write");

  AST_RX_THR_WRITE: assert property (
    s_wr_ctrl |=>
      rx_fifo_midlevel == $past(pwdata[PMC_CTRL_RXTHR_LO +: 2]))
    else $error("rx threshold did not follow write");

  AST_TX_THR_WRITE: assert property (
    s_wr_ctrl |=>
      tx_fifo_midlevel == $past(pwdata[PMC_CTRL_TXTHR_LO +: 2]) &&
      tx_clk_shifted == $past(pwdata[PMC_CTRL_TXSHIFT_BIT]) &&
      rx_clk_shifted == $past(pwdata[PMC_CTRL_RXSHIFT_BIT]))
    else $error("tx threshold or clock shift did not follow write");

  AST_SKIP_WRITE: assert property (
    s_wr_ctrl2 |=>
      async_fifo_skip == $past(pwdata[PMC_CTRL2_SKIP_BIT]) &&
      async_skip_clock_lag == $past(pwdata[PMC_CTRL2_LAG_BIT]) &&
      low_latency_10_100 == $past(pwdata[PMC_CTRL2_LOWLAT_BIT]))
    else $error("second control did not follow write");

  AST_STATUS_READ: assert property (
    s_rd_start(PMC_IDX_NEG_STS) |=>
      prdata[1:0] == {$past(page_sync), $past(done_sync)} &&
      prdata[31:2] == 30'h0)
    else $error("negotiation status read wrong");

  AST_RECOVERY_WRITE: assert property (
    wr_done && hit(paddr, PMC_IDX_FE_CFG) && pstrb[1] && pstrb[0] |=>
      unlock_recovery_ms == $past(pwdata[PMC_FE_RECOV_LO +: 4]) &&
      unlock_timeout_off == $past(pwdata[PMC_FE_TOOFF_BIT]))
    else $error("recovery field did not follow write");

  AST_FE_LOW_WRITE: assert property (
    s_wr_fe_lo |=>
      scrambling_off == $past(pwdata[PMC_FE_SCROFF_BIT]) &&
      early_receive_valid == $past(pwdata[PMC_FE_EARLY_BIT]) &&
      force_link_good == $past(pwdata[PMC_FE_FORCE_BIT]))
    else $error("fast ethernet low bits did not follow write");

  AST_FE_DETECT_WRITE: assert property (
    s_wr_fe_lo |=>
      enhanced_line_code_detect == $past(pwdata[PMC_FE_LINECODE_BIT]) &&
      enhanced_gap_detect == $past(pwdata[PMC_FE_GAP_BIT]) &&
      odd_nibble_detect == $past(pwdata[PMC_FE_ODD_BIT]))
    else $error("detection enables did not follow write");

  AST_ONE_WAIT: assert property (
    access |=> pready ##1 !pready)
    else $error("answer timing wrong");

  AST_UNMAPPED_ERR: assert property (
    access && !mapped(paddr) |=> pready && pslverr)
    else $error("unmapped access not flagged");

  // registers are 16 bits wide; the upper half of the bus word stays zero
  AST_UPPER_HALF_ZERO: assert property (
    access && !pwrite |=> prdata[PMC_DATA_W-1:PMC_REG_W] == 16'h0000)
    else $error("read data upper half not zero");

  AST_FE_RESERVED_ZERO: assert property (
    s_rd_start(PMC_IDX_FE_CFG) |=>
      (prdata[PMC_REG_W-1:0] & ~PMC_FE_MASK) == 16'h0000)
    else $error("fast ethernet reserved bits not zero");

  AST_CTRL2_RESERVED_ZERO: assert property (
    s_rd_start(PMC_IDX_CTRL2) |=>
      (prdata[PMC_REG_W-1:0] & ~PMC_CTRL2_MASK) == 16'h0000)
    else $error("second control reserved bits not zero");

  // clock enable low holds every register and the bus answer
  AST_CE_FREEZE: assert property (
    !ce |=> $stable(ctrl) && $stable(ctrl2) && $stable(fe_cfg) &&
      $stable(pready) && $stable(prdata))
    else $error("state moved while clock enable low");

  // the strap reaches the enable bit unless a write takes the same edge
  sequence s_strap_load;
    ce && STRAP_ENABLE && !strap_taken && strap_cnt == STRAP_LOAD &&
      !(wr_done && hit(paddr, PMC_IDX_CTRL) && pstrb[0]);
  endsequence

  AST_STRAP_LOAD: assert property (
    s_strap_load |=> parallel_if_enable == $past(strap_sync))
    else $error("strap not loaded into interface enable");

endmodule // pmc_config_regs

`default_nettype wire

// *** src/pmc_pkg.sv ***
package pmc_pkg;

  // bus geometry
  localparam int PMC_ADDR_W = 12;
  localparam int PMC_DATA_W = 32;
  localparam int PMC_REG_W = 16;

  // register indices; byte address is four times the index
  localparam logic [7:0] PMC_IDX_CTRL = 8'h32;
  localparam logic [7:0] PMC_IDX_CTRL2 = 8'h33;
  localparam logic [7:0] PMC_IDX_NEG_STS = 8'h37;
  localparam logic [7:0] PMC_IDX_FE_CFG = 8'h43;

  // mac_parallel_if_control fields
  localparam int PMC_CTRL_EN_BIT = 7;
  localparam int PMC_CTRL_RXTHR_LO = 5;
  localparam int PMC_CTRL_TXTHR_LO = 3;
  localparam int PMC_CTRL_TXSHIFT_BIT = 1;
  localparam int PMC_CTRL_RXSHIFT_BIT = 0;
  localparam int PMC_CTRL_UPPER_LO = 8;
  localparam logic [15:0] PMC_CTRL_MASK = 16'h00FB;
  localparam logic [15:0] PMC_CTRL_RST = 16'h00D0;
  localparam logic [15:0] PMC_CTRL_RST_STRAP = 16'h0050;
  localparam logic [1:0] PMC_THR_NOMINAL = 2'h2;

  // mac_parallel_if_control_two fields
  localparam int PMC_CTRL2_SKIP_BIT = 4;
  localparam int PMC_CTRL2_LAG_BIT = 3;
  localparam int PMC_CTRL2_LOWLAT_BIT = 2;
  localparam logic [15:0] PMC_CTRL2_MASK = 16'h001C;
  localparam logic [15:0] PMC_CTRL2_RST = 16'h0000;

  // serial_if_negotiation_status fields
  localparam int PMC_STS_PAGE_BIT = 1;
  localparam int PMC_STS_DONE_BIT = 0;

  // fast_ethernet_rx_config fields
  localparam int PMC_FE_TOOFF_BIT = 11;
  localparam int PMC_FE_RECOV_LO = 7;
  localparam int PMC_FE_FORCE_BIT = 6;
  localparam int PMC_FE_LINECODE_BIT = 5;
  localparam int PMC_FE_GAP_BIT = 4;
  localparam int PMC_FE_SCROFF_BIT = 2;
  localparam int PMC_FE_ODD_BIT = 1;
  localparam int PMC_FE_EARLY_BIT = 0;
  localparam logic [15:0] PMC_FE_MASK = 16'h0FF7;
  localparam logic [15:0] PMC_FE_RST = 16'h07A0;

  // cycles after reset release for the strap synchroniser stages to fill; the strap is taken two edges later
  localparam logic [1:0] PMC_STRAP_SETTLE = 2'h3;

endpackage

// *** src/pmc_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none

module pmc_sync3 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic din,
  output logic dout
);

  logic s1;
  logic s2;
  logic s3;

  // three stages; only s2 and s3 are looked at past the first flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= 1'b0;
    end else if (ce && (s2 == s3)) begin
      dout <= s3;
    end
  end

endmodule // pmc_sync3

`default_nettype wire

// *** bench/pmc_serial_peer.sv ***
`timescale 1ns/1ps
`default_nettype none

// stands in for the serial link partner: negotiation status levels
// change with no relation to pclk, so the synchronisers get real work
module pmc_serial_peer #(
  parameter int LAG_NS = 3
) (
  input wire logic page_cmd,
  input wire logic done_cmd,
  output logic serial_page_in,
  output logic serial_done_in
);
  initial begin
    serial_page_in = 1'b0;
    serial_done_in = 1'b0;
  end
  // each status level follows its command after the same LAG_NS delay
  always @(page_cmd) serial_page_in <= #(LAG_NS) page_cmd;
  always @(done_cmd) serial_done_in <= #(LAG_NS) done_cmd;
endmodule // pmc_serial_peer

`default_nettype wire

// *** bench/pmc_config_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module pmc_config_regs_tb;
  import pmc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, page_cmd, done_cmd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seen, expv;
  logic [3:0] pstrb;
  logic pready, pslverr, spg, sdn, ce, strap_pin, spe;
  logic [1:0] rxm, txm;
  logic [3:0] rec;
  logic pe, txs, rxs, skp, lag, lowl, tof, flg, lcd, gap, scr, odd, erv;
  logic [15:0] c_m, c2_m, f_m;
  int fail_count, cmp_count, seed;
  // one note per transfer: expected error flag, data, whether data counts
  typedef struct {logic err; logic [31:0] d; bit chk;} pmc_note_t;
  pmc_note_t notes[$];

  pmc_config_regs i_pmc_config_regs (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .strap_parallel_if_en(1'b0),
    .serial_page_in(spg), .serial_done_in(sdn), .parallel_if_enable(pe),
    .rx_fifo_midlevel(rxm), .tx_fifo_midlevel(txm), .tx_clk_shifted(txs),
    .rx_clk_shifted(rxs), .async_fifo_skip(skp), .async_skip_clock_lag(lag),
    .low_latency_10_100(lowl), .unlock_timeout_off(tof),
    .unlock_recovery_ms(rec), .force_link_good(flg),
    .enhanced_line_code_detect(lcd), .enhanced_gap_detect(gap),
    .scrambling_off(scr), .odd_nibble_detect(odd),
    .early_receive_valid(erv));

  // second copy takes its enable from the strap pin; its bus stays idle
  pmc_config_regs #(.STRAP_ENABLE(1'b1)) i_pmc_config_regs_strap (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(1'b0),
    .penable(1'b0), .pwrite(1'b0), .paddr(12'h000), .pwdata(32'h0),
    .pstrb(4'h0), .prdata(), .pready(), .pslverr(),
    .strap_parallel_if_en(strap_pin), .serial_page_in(1'b0),
    .serial_done_in(1'b0), .parallel_if_enable(spe),
    .rx_fifo_midlevel(), .tx_fifo_midlevel(), .tx_clk_shifted(),
    .rx_clk_shifted(), .async_fifo_skip(), .async_skip_clock_lag(),
    .low_latency_10_100(), .unlock_timeout_off(),
    .unlock_recovery_ms(), .force_link_good(),
    .enhanced_line_code_detect(), .enhanced_gap_detect(),
    .scrambling_off(), .odd_nibble_detect(), .early_receive_valid());

  pmc_serial_peer i_pmc_serial_peer (.page_cmd(page_cmd),
    .done_cmd(done_cmd), .serial_page_in(spg), .serial_done_in(sdn));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic cmp(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // monitor: every completed transfer retires the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) cmp("orphan", 32'h1, 32'h0);
      else begin
        cmp("pslverr", {31'h0, pslverr}, {31'h0, notes[0].err});
        if (notes[0].chk) cmp("prdata", prdata, notes[0].d);
        void'(notes.pop_front());
      end
    end
  end

  // apb master: hold the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic err, input logic [31:0] e, input bit chk);
    int n;
    notes.push_back('{err, e, chk});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  function automatic logic [11:0] adr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [15:0] m_lanes(input logic [3:0] s);
    return {{8{s[1]}}, {8{s[0]}}};
  endfunction

  task automatic rd(input logic [7:0] idx, input logic [15:0] e);
    apb(1'b0, adr(idx), 32'h0, 4'h0, 1'b0, {16'h0, e}, 1'b1);
  endtask

  // write, mirror into the bench model, then compare every level output
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    input logic [3:0] s);
    logic [15:0] m;
    m = {s[1] ? d[15:8] : 8'h00, s[0] ? d[7:0] : 8'h00};
    apb(1'b1, adr(idx), d, s, 1'b0, 32'h0, 1'b0);
    if (idx == PMC_IDX_CTRL) c_m = (c_m & ~{8'h0, {8{s[0]}}} & 16'hFFFF)
      | (m & PMC_CTRL_MASK & {{8{s[1]}}, {8{s[0]}}}) | (c_m & ~m_lanes(s));
    if (idx == PMC_IDX_CTRL2) c2_m = (c2_m & ~m_lanes(s))
      | (m & PMC_CTRL2_MASK);
    if (idx == PMC_IDX_FE_CFG) f_m = (f_m & ~m_lanes(s)) | (m & PMC_FE_MASK);
    @(posedge pclk);
    seen = {11'h0, pe, rxm, txm, txs, rxs, skp, lag, lowl, tof, rec, flg,
            lcd, gap, scr, odd, erv};
    expv = {11'h0, c_m[7], c_m[6:3], c_m[1:0], c2_m[4:2], f_m[11:4],
            f_m[2:0]};
    cmp("outputs", seen, expv);
  endtask

  initial begin
    seed = 32'h724b02bd;
    presetn = 1'b0;
    {psel, penable, pwrite, page_cmd, done_cmd} = '0;
    ce = 1'b1;
    strap_pin = 1'b1;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    fail_count = 0;
    cmp_count = 0;
    c_m = 16'h00D0;
    c2_m = 16'h0000;
    f_m = 16'h07A0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values
    rd(PMC_IDX_CTRL, 16'h00D0);
    rd(PMC_IDX_CTRL2, 16'h0000);
    rd(PMC_IDX_NEG_STS, 16'h0000);
    rd(PMC_IDX_FE_CFG, 16'h07A0);
    cmp("strap_enable", {31'h0, spe}, {31'h0, strap_pin});
    // all ones: reserved bits stay zero
    wr(PMC_IDX_CTRL, 32'hFFFFFFFF, 4'hF);
    rd(PMC_IDX_CTRL, 16'h00FB);
    wr(PMC_IDX_CTRL2, 32'hFFFFFFFF, 4'hF);
    rd(PMC_IDX_CTRL2, 16'h001C);
    wr(PMC_IDX_FE_CFG, 32'hFFFFFFFF, 4'hF);
    rd(PMC_IDX_FE_CFG, 16'h0FF7);
    // lower lane only: upper bits keep their value
    wr(PMC_IDX_FE_CFG, 32'h00000000, 4'h1);
    rd(PMC_IDX_FE_CFG, f_m);
    // random contents through every writable register
    repeat (12) begin
      wr(PMC_IDX_CTRL, $random(seed), 4'h3);
      wr(PMC_IDX_CTRL2, $random(seed), 4'h3);
      wr(PMC_IDX_FE_CFG, $random(seed), 4'h3);
      rd(PMC_IDX_CTRL, c_m);
      rd(PMC_IDX_FE_CFG, f_m);
    end
    // reset in mid-run: every register and the strap load start again
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    c_m = PMC_CTRL_RST;
    c2_m = PMC_CTRL2_RST;
    f_m = PMC_FE_RST;
    rd(PMC_IDX_CTRL, c_m);
    rd(PMC_IDX_CTRL2, c2_m);
    rd(PMC_IDX_FE_CFG, f_m);
    cmp("strap_enable", {31'h0, spe}, {31'h0, strap_pin});
    // clock enable low stalls the slave; the write lands once it rises
    ce <= 1'b0;
    fork
      begin
        repeat (5) @(posedge pclk);
        ce <= 1'b1;
      end
    join_none
    wr(PMC_IDX_CTRL2, 32'h00000014, 4'h1);
    rd(PMC_IDX_CTRL2, c2_m);
    // unmapped place refused; status register ignores writes
    apb(1'b1, 12'h004, 32'hFFFFFFFF, 4'hF, 1'b1, 32'h0, 1'b0);
    apb(1'b0, 12'h004, 32'h0, 4'h0, 1'b1, 32'h0, 1'b0);
    apb(1'b1, adr(PMC_IDX_NEG_STS), 32'hFFFF, 4'hF, 1'b0, 32'h0, 1'b0);
    rd(PMC_IDX_NEG_STS, 16'h0000);
    // page first, then completion, then the link drops again
    page_cmd <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(PMC_IDX_NEG_STS, 16'h0002);
    done_cmd <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(PMC_IDX_NEG_STS, 16'h0003);
    {page_cmd, done_cmd} <= 2'b00;
    repeat (8) @(posedge pclk);
    rd(PMC_IDX_NEG_STS, 16'h0000);
    repeat (2) @(posedge pclk);
    cmp("notes_left", notes.size(), 32'h0);
    tally_and_finish();
  end
endmodule // pmc_config_regs_tb

`default_nettype wire
